// >>> rtl/pusir_pkg.sv
// Package for the power unit status and interrupt register bank.
// Holds offsets, field positions, reset values and timing counts.
// Assumes a 250 MHz system clock and a 14-bit word-aligned APB address.
package pusir_pkg;

    localparam int ADDR_W = 14;
    localparam int CLK_PERIOD_NS = 4;

    // Monitor latency budgets
    localparam int BUS_MON_LAT_US = 10;
    localparam int CONTACT_MON_LAT_US = 75;
    localparam int BUS_MON_LAT_CYC = BUS_MON_LAT_US * 1000 / CLK_PERIOD_NS;
    localparam int CONTACT_MON_LAT_CYC =
        CONTACT_MON_LAT_US * 1000 / CLK_PERIOD_NS;

    // Write strobes of the interrupt block stay high this many cycles
    localparam logic [1:0] STB_HOLD = 2'h2;
    localparam int IRQ_COUNT = 7;

    localparam logic [ADDR_W-1:0] OFF_STATUS = 14'h0000;
    localparam logic [ADDR_W-1:0] OFF_IRQ_EN_CLR = 14'h3fd8;
    localparam logic [ADDR_W-1:0] OFF_IRQ_EN_SET = 14'h3fdc;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 14'h3fe0;
    localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 14'h3fe4;
    localparam logic [ADDR_W-1:0] OFF_IRQ_ST_CLR = 14'h3fe8;
    localparam logic [ADDR_W-1:0] OFF_IRQ_ST_SET = 14'h3fec;

    // Plain read-write control words, index order
    localparam int CTL_N = 5;
    localparam int CTL_MON = 0;
    localparam int CTL_TXREG = 1;
    localparam int CTL_CONV = 2;
    localparam int CTL_INT_A = 3;
    localparam int CTL_INT_B = 4;
    localparam logic [ADDR_W-1:0] CTL_OFF [CTL_N] =
        '{14'h0004, 14'h0008, 14'h000c, 14'h0010, 14'h0014};
    localparam logic [31:0] CTL_RST [CTL_N] =
        '{32'h0000040e, 32'h04000000, 32'h00000000, 32'h00000000,
          32'h00000000};
    localparam logic [31:0] STATUS_RST = 32'h00000000;

    // Monitor control fields
    localparam int MON_EN_BUS2_BIT = 5;
    localparam int MON_EN_CONTACT_BIT = 6;

    // Power status fields
    localparam int ST_LOWPWR_BIT = 24;
    localparam int ST_TX5V_BIT = 23 - 1;
    localparam int ST_CONTACT_BIT = 21;
    localparam int ST_BUS2_BIT = 20;
    localparam int ST_PAD_BIT = 19;
    localparam int ST_CARD_OVL_BIT = 11;
    localparam int ST_CONV_OVL_BIT = 10;
    localparam int ST_DET_LSB = 3;
    localparam int ST_DET_MSB = 9;
    localparam int ST_MEAS_VALID_BIT = 2;
    localparam int ST_SM_DONE_BIT = 1;
    localparam int ST_THR_HIT_BIT = 0;

    // Self-clearing strobe registers
    localparam int STB_N = 4;
    localparam int STB_ECLR = 0;
    localparam int STB_ESET = 1;
    localparam int STB_SCLR = 2;
    localparam int STB_SSET = 3;

    // Analogue signals seen by the digital part
    typedef struct packed {
        logic bus_supply_first_monitor;
        logic bus_supply_second_monitor;
        logic contact_supply_monitor;
        logic battery_reg_lowpower;
        logic tx_reg_five_volt_ok;
        logic pad_supply_out_ok;
        logic card_reg_overload;
        logic converter_overload;
        logic [6:0] tx_current_detect_value;
        logic tx_current_measure_valid;
        logic tx_detect_sm_done;
        logic tx_current_threshold_hit;
    } pusir_ana_s;

endpackage : pusir_pkg

// >>> rtl/pusir_mon_filter.sv
// Supply monitor follower with a bounded settle time.
// Assumes the raw comparator level is already synchronous to clk.
`timescale 1ns/1ps
module pusir_mon_filter #(
    parameter int LIMIT = 2499
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic en,
    input wire logic raw,
    output logic ok
);
    localparam int CW = $clog2(LIMIT + 1);

    logic [CW-1:0] cnt_q;
    logic ok_q;
    wire differ = en && (raw != ok_q);
    wire expire = differ && (cnt_q == CW'(LIMIT - 1));

    // Output follows once raw has disagreed for LIMIT cycles, so
    // a crossing shows within LIMIT cycles and glitches are dropped
    always_ff @(posedge clk) begin
        if (srst || !en) begin
            cnt_q <= '0;
            ok_q <= 1'b0;
        end else if (expire) begin
            cnt_q <= '0;
            ok_q <= raw;
        end else if (differ) begin
            cnt_q <= cnt_q + CW'(1);
        end else begin
            cnt_q <= '0;
        end
    end

    assign ok = ok_q;

    a_filter_bound: assert property (
        @(posedge clk) disable iff (srst) cnt_q < CW'(LIMIT))
        else $error("monitor settle counter past its bound");

    a_filter_follow: assert property (
        @(posedge clk) disable iff (srst)
        expire |=> (ok_q == $past(raw)))
        else $error("monitor output did not follow after settle time");

endmodule : pusir_mon_filter

// >>> rtl/pusir_regs.sv
// Power unit register bank: status word, control words and
// interrupt block, reached over a 32-bit APB slave port.
// Assumes analogue inputs and events are synchronous to CLOCK.
`timescale 1ns/1ps
module pusir_regs
    import pusir_pkg::*;
#(
    parameter int IRQ_N = IRQ_COUNT,
    parameter int BUS_MON_CYC = BUS_MON_LAT_CYC,
    parameter int CONTACT_MON_CYC = CONTACT_MON_LAT_CYC
) (
    input wire logic CLOCK,
    input wire logic SRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input pusir_ana_s ANA_IN,
    input wire logic [IRQ_N-1:0] IRQ_EVENT,
    output logic BUS_SUPPLY_FIRST_OK,
    output logic [31:0] MON_CONTROL,
    output logic [31:0] TXREG_CONTROL,
    output logic [31:0] CONV_CONTROL,
    output logic [31:0] INTERNAL_A,
    output logic [31:0] INTERNAL_B,
    output logic IRQ
);

    function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] off);
        addr_is = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
    endfunction : addr_is

    // Bus handshake state
    logic ready_q;
    logic [31:0] rdata_q;
    logic err_q;

    // Register state
    logic [31:0] status_q;
    logic [31:0] ctl_q [CTL_N];
    logic [IRQ_N-1:0] irq_st_q;
    logic [IRQ_N-1:0] irq_en_q;
    logic [IRQ_N-1:0] stb_q [STB_N];
    logic [1:0] age_q [STB_N];
    logic irq_q;

    // Monitor raw levels, enables and filtered outputs
    logic [2:0] mon_ok;
    logic [2:0] mon_raw;
    logic [2:0] mon_en;

    // Address decode
    wire hit_status = addr_is(PADDR, OFF_STATUS);
    wire hit_en_clr = addr_is(PADDR, OFF_IRQ_EN_CLR);
    wire hit_en_set = addr_is(PADDR, OFF_IRQ_EN_SET);
    wire hit_irq_st = addr_is(PADDR, OFF_IRQ_STATUS);
    wire hit_irq_en = addr_is(PADDR, OFF_IRQ_ENABLE);
    wire hit_st_clr = addr_is(PADDR, OFF_IRQ_ST_CLR);
    wire hit_st_set = addr_is(PADDR, OFF_IRQ_ST_SET);
    wire [CTL_N-1:0] hit_ctl;
    wire hit_wo = hit_en_clr || hit_en_set || hit_st_clr || hit_st_set;
    wire hit_any = hit_status || hit_irq_st || hit_irq_en || hit_wo ||
                   (|hit_ctl);

    // Setup phase is taken when no answer is pending; the access
    // phase then always completes with no wait state
    wire setup = PSEL && !PENABLE && !ready_q;
    wire access = PSEL && PENABLE && ready_q;
    wire wr = access && PWRITE && hit_any;
    wire [IRQ_N-1:0] wdata = PWDATA[IRQ_N-1:0];

    wire wr_en_clr = wr && hit_en_clr;
    wire wr_en_set = wr && hit_en_set;
    wire wr_irq_en = wr && hit_irq_en;
    wire wr_st_clr = wr && hit_st_clr;
    wire wr_st_set = wr && hit_st_set;
    wire [STB_N-1:0] wr_stb;
    assign wr_stb[STB_ECLR] = wr_en_clr;
    assign wr_stb[STB_ESET] = wr_en_set;
    assign wr_stb[STB_SCLR] = wr_st_clr;
    assign wr_stb[STB_SSET] = wr_st_set;

    // APB answer, registered from the setup cycle
    wire [31:0] irq_st_word = 32'(irq_st_q);
    wire [31:0] irq_en_word = 32'(irq_en_q);
    logic [31:0] ctl_rd;
    wire [31:0] rd_word =
        hit_status ? status_q :
        hit_irq_st ? irq_st_word :
        hit_irq_en ? irq_en_word :
        ctl_rd;

    always_comb begin
        ctl_rd = '0;
        for (int i = 0; i < CTL_N; i++) begin
            if (hit_ctl[i]) begin
                ctl_rd = ctl_q[i];
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            ready_q <= 1'b0;
            rdata_q <= '0;
            err_q <= 1'b0;
        end else if (setup) begin
            ready_q <= 1'b1;
            rdata_q <= PWRITE ? 32'h00000000 : rd_word;
            err_q <= !hit_any;
        end else begin
            ready_q <= 1'b0;
            rdata_q <= '0;
            err_q <= 1'b0;
        end
    end

    assign PREADY = ready_q;
    assign PRDATA = rdata_q;
    assign PSLVERR = err_q;

    // Plain read-write control words
    generate
        for (genvar g = 0; g < CTL_N; g++) begin : g_ctl
            assign hit_ctl[g] = addr_is(PADDR, CTL_OFF[g]);
            always_ff @(posedge CLOCK) begin
                if (SRST) begin
                    ctl_q[g] <= CTL_RST[g];
                end else if (wr && hit_ctl[g]) begin
                    ctl_q[g] <= PWDATA;
                end
            end
        end
    endgenerate

    assign MON_CONTROL = ctl_q[CTL_MON];
    assign TXREG_CONTROL = ctl_q[CTL_TXREG];
    assign CONV_CONTROL = ctl_q[CTL_CONV];
    assign INTERNAL_A = ctl_q[CTL_INT_A];
    assign INTERNAL_B = ctl_q[CTL_INT_B];

    // Supply monitors; the first bus monitor has no enable here
    assign mon_raw[0] = ANA_IN.bus_supply_first_monitor;
    assign mon_raw[1] = ANA_IN.bus_supply_second_monitor;
    assign mon_raw[2] = ANA_IN.contact_supply_monitor;
    assign mon_en[0] = 1'b1;
    assign mon_en[1] = ctl_q[CTL_MON][MON_EN_BUS2_BIT];
    assign mon_en[2] = ctl_q[CTL_MON][MON_EN_CONTACT_BIT];

    // One cycle is left for the status register behind the filter
    generate
        for (genvar m = 0; m < 3; m++) begin : g_mon
            localparam int LIM =
                (m == 2) ? CONTACT_MON_CYC - 1 : BUS_MON_CYC - 1;
            pusir_mon_filter #(
                .LIMIT(LIM)
            ) u_filter (
                .clk(CLOCK),
                .srst(SRST),
                .en(mon_en[m]),
                .raw(mon_raw[m]),
                .ok(mon_ok[m])
            );
        end
    endgenerate

    // Live status word, sampled every cycle
    wire [31:0] stat_w;
    assign stat_w[31:25] = '0;
    assign stat_w[ST_LOWPWR_BIT] = ANA_IN.battery_reg_lowpower;
    assign stat_w[23] = 1'b0;
    assign stat_w[ST_TX5V_BIT] = ANA_IN.tx_reg_five_volt_ok;
    assign stat_w[ST_CONTACT_BIT] = mon_ok[2];
    assign stat_w[ST_BUS2_BIT] = mon_ok[1];
    assign stat_w[ST_PAD_BIT] = ANA_IN.pad_supply_out_ok;
    assign stat_w[18:12] = '0;
    assign stat_w[ST_CARD_OVL_BIT] = ANA_IN.card_reg_overload;
    assign stat_w[ST_CONV_OVL_BIT] = ANA_IN.converter_overload;
    assign stat_w[ST_DET_MSB:ST_DET_LSB] =
        ANA_IN.tx_current_detect_value;
    assign stat_w[ST_MEAS_VALID_BIT] =
        ANA_IN.tx_current_measure_valid;
    assign stat_w[ST_SM_DONE_BIT] = ANA_IN.tx_detect_sm_done;
    assign stat_w[ST_THR_HIT_BIT] =
        ANA_IN.tx_current_threshold_hit;

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            status_q <= STATUS_RST;
        end else begin
            status_q <= stat_w;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            BUS_SUPPLY_FIRST_OK <= 1'b0;
        end else begin
            BUS_SUPPLY_FIRST_OK <= mon_ok[0];
        end
    end

    // Self-clearing write strobes; a rewrite restarts the hold
    generate
        for (genvar s = 0; s < STB_N; s++) begin : g_stb
            always_ff @(posedge CLOCK) begin
                if (SRST) begin
                    stb_q[s] <= '0;
                    age_q[s] <= '0;
                end else if (wr_stb[s]) begin
                    stb_q[s] <= wdata;
                    age_q[s] <= STB_HOLD;
                end else if (age_q[s] == 2'h1) begin
                    stb_q[s] <= '0;
                    age_q[s] <= '0;
                end else if (age_q[s] != 2'h0) begin
                    age_q[s] <= age_q[s] - 2'h1;
                end
            end
        end
    endgenerate

    // Latched status: hardware events and software set beat clear
    wire [IRQ_N-1:0] st_d =
        (irq_st_q & ~stb_q[STB_SCLR]) |
        stb_q[STB_SSET] |
        IRQ_EVENT;

    // Direct enable write first, then set over clear
    wire [IRQ_N-1:0] en_d =
        wr_irq_en ? wdata :
        (irq_en_q & ~stb_q[STB_ECLR]) |
        stb_q[STB_ESET];

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            irq_st_q <= '0;
            irq_en_q <= '0;
        end else begin
            irq_st_q <= st_d;
            irq_en_q <= en_d;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irq_st_q & irq_en_q);
        end
    end

    assign IRQ = irq_q;

    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (SRST);

    sequence s_sset_write;
        wr_st_set && (wdata != '0);
    endsequence

    sequence s_sset_held;
        (stb_q[STB_SSET] != '0) [*2];
    endsequence

    sequence s_sset_gone;
        (stb_q[STB_SSET] == '0) || $past(wr_st_set);
    endsequence

    a_strobe_self_clear: assert property (
        s_sset_write |=> s_sset_held ##1 s_sset_gone)
        else $error("status set strobe not gone after two cycles");

    a_status_set_force: assert property (
        (stb_q[STB_SSET] != '0) |=>
        ((irq_st_q & $past(stb_q[STB_SSET])) == $past(stb_q[STB_SSET])))
        else $error("status set strobe did not force status bits");

    a_status_clear_bits: assert property (
        (stb_q[STB_SCLR] != '0 && stb_q[STB_SSET] == '0 &&
         IRQ_EVENT == '0) |=>
        ((irq_st_q & $past(stb_q[STB_SCLR])) == '0))
        else $error("status clear strobe left a latched bit");

    a_status_sticky_hold: assert property (
        (stb_q[STB_SCLR] == '0) |=>
        ((irq_st_q & $past(irq_st_q)) == $past(irq_st_q)))
        else $error("latched status bit dropped without a clear");

    a_enable_set_bits: assert property (
        (stb_q[STB_ESET] != '0 && !wr_irq_en) |=>
        ((irq_en_q & $past(stb_q[STB_ESET])) == $past(stb_q[STB_ESET])))
        else $error("enable set strobe did not set enables");

    a_enable_clear_bits: assert property (
        (stb_q[STB_ECLR] != '0 && stb_q[STB_ESET] == '0 &&
         !wr_irq_en) |=>
        ((irq_en_q & $past(stb_q[STB_ECLR])) == '0))
        else $error("enable clear strobe left an enable set");

    a_irq_or_mask: assert property (
        ##1 (IRQ == |($past(irq_st_q) & $past(irq_en_q))))
        else $error("interrupt line differs from masked status OR");

    a_ready_one_cycle: assert property (
        setup |=> PREADY ##1 !PREADY)
        else $error("bus answer not a single ready cycle");

    a_reserved_zero: assert property (
        (setup && !PWRITE && hit_status) |=>
        (PRDATA[31:25] == '0 && PRDATA[23] == 1'b0 &&
         PRDATA[18:12] == '0))
        else $error("reserved status bits read nonzero");

    a_monctl_reset: assert property (
        $past(SRST) |-> (MON_CONTROL == CTL_RST[CTL_MON]))
        else $error("monitor control wrong after reset");

    a_status_live: assert property (
        ##1 (status_q[ST_DET_MSB:ST_DET_LSB] ==
             $past(ANA_IN.tx_current_detect_value)))
        else $error("status word does not follow detection result");

endmodule : pusir_regs

// >>> verif/pusir_apb_master.sv
// Processor-side APB master model for the power unit register bank.
// Assumes a single rising-edge clock shared with the bank.
`timescale 1ns/1ps
module pusir_apb_master
    import pusir_pkg::*;
(
    input wire logic CLOCK,
    output logic PSEL,
    output logic PENABLE,
    output logic PWRITE,
    output logic [ADDR_W-1:0] PADDR,
    output logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR
);
    initial begin
        PSEL = 1'b0;
        PENABLE = 1'b0;
        PWRITE = 1'b0;
        PADDR = '0;
        PWDATA = '0;
    end

    // One transfer; unknown result if ready never comes
    task automatic xfer(input logic wr, input logic [ADDR_W-1:0] addr,
                        input logic [31:0] wdata, output logic [31:0] rdata,
                        output logic err);
        int n;
        rdata = 'x;
        err = 1'bx;
        @(negedge CLOCK);
        PSEL = 1'b1;
        PENABLE = 1'b0;
        PWRITE = wr;
        PADDR = addr;
        PWDATA = wr ? wdata : ~PWDATA;
        @(negedge CLOCK);
        PENABLE = 1'b1;
        n = 0;
        while (n < 16) begin
            @(posedge CLOCK);
            n++;
            if (PREADY === 1'b1) begin
                rdata = PRDATA;
                err = PSLVERR;
                n = 16;
            end
        end
        // Released lines flip so stale values cannot pass
        @(negedge CLOCK);
        PSEL = 1'b0;
        PENABLE = 1'b0;
        PADDR = ~PADDR;
        PWDATA = ~PWDATA;
    endtask : xfer
endmodule : pusir_apb_master

// >>> verif/pusir_regs_test.sv
// Self-checking bench for the power unit register bank.
// Assumes the bank is driven only through APB and its input ports.
`timescale 1ns/1ps
module pusir_regs_test
    import pusir_pkg::*;
;
    localparam int BUS_CYC = 4;
    localparam int CON_CYC = 6;
    logic CLOCK = 1'b0;
    logic SRST = 1'b1;
    logic PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ, BUS_SUPPLY_FIRST_OK;
    logic [ADDR_W-1:0] PADDR;
    logic [31:0] PWDATA, PRDATA;
    logic [31:0] MON_CONTROL, TXREG_CONTROL, CONV_CONTROL;
    logic [31:0] INTERNAL_A, INTERNAL_B;
    pusir_ana_s ANA_IN = '0;
    logic [6:0] IRQ_EVENT = '0;
    int error_cnt = 0;
    int comparisons = 0;
    logic [13:0] offs [5] = '{14'h4, 14'h8, 14'hc, 14'h10, 14'h14};
    logic [31:0] rstv [5] =
        '{32'h0000040e, 32'h04000000, 32'h0, 32'h0, 32'h0};
    logic [13:0] zoff [6] =
        '{14'h3fd8, 14'h3fdc, 14'h3fe0, 14'h3fe4, 14'h3fe8, 14'h3fec};

    always #2 CLOCK = ~CLOCK;

    pusir_regs #(
        .BUS_MON_CYC(BUS_CYC), .CONTACT_MON_CYC(CON_CYC)
    ) i_pusir_regs (
        .CLOCK(CLOCK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .ANA_IN(ANA_IN),
        .IRQ_EVENT(IRQ_EVENT), .BUS_SUPPLY_FIRST_OK(BUS_SUPPLY_FIRST_OK),
        .MON_CONTROL(MON_CONTROL), .TXREG_CONTROL(TXREG_CONTROL),
        .CONV_CONTROL(CONV_CONTROL), .INTERNAL_A(INTERNAL_A),
        .INTERNAL_B(INTERNAL_B), .IRQ(IRQ));

    pusir_apb_master i_pusir_apb_master (
        .CLOCK(CLOCK), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check

    // Writes answer with zero data; x and xe are the expected answer
    task automatic acc(input logic w, input logic [13:0] a,
                       input logic [31:0] d, input logic [31:0] x,
                       input logic xe);
        logic [31:0] r;
        logic e;
        i_pusir_apb_master.xfer(w, a, d, r, e);
        check(r, x);
        check({31'h0, e}, {31'h0, xe});
    endtask : acc

    function automatic logic [31:0] exp_st(input pusir_ana_s a,
                                           input logic on);
        logic [31:0] s;
        s = '0;
        s[24] = a.battery_reg_lowpower;
        s[22] = a.tx_reg_five_volt_ok;
        s[21] = a.contact_supply_monitor & on;
        s[20] = a.bus_supply_second_monitor & on;
        s[19] = a.pad_supply_out_ok;
        s[11] = a.card_reg_overload;
        s[10] = a.converter_overload;
        s[9:3] = a.tx_current_detect_value;
        s[2] = a.tx_current_measure_valid;
        s[1] = a.tx_detect_sm_done;
        s[0] = a.tx_current_threshold_hit;
        return s;
    endfunction : exp_st

    task automatic t_reset;
        acc(1'b0, 14'h0, 0, 0, 1'b0);
        for (int i = 0; i < 5; i++) begin
            acc(1'b0, offs[i], 0, rstv[i], 1'b0);
        end
        for (int i = 0; i < 6; i++) begin
            acc(1'b0, zoff[i], 0, 0, 1'b0);
        end
        acc(1'b0, 14'h0018, 0, 0, 1'b1);
        acc(1'b0, 14'h3ff0, 0, 0, 1'b1);
        check(TXREG_CONTROL, 32'h04000000);
        check({31'h0, BUS_SUPPLY_FIRST_OK}, 32'h0);
        check({31'h0, IRQ}, 0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_ctrl;
        for (int i = 0; i < 5; i++) begin
            acc(1'b1, offs[i], 32'h5a5a0000 | i, 0, 1'b0);
        end
        for (int i = 0; i < 5; i++) begin
            acc(1'b0, offs[i], 0, 32'h5a5a0000 | i, 1'b0);
        end
        check(MON_CONTROL, 32'h5a5a0000);
        check(TXREG_CONTROL, 32'h5a5a0001);
        check(CONV_CONTROL, 32'h5a5a0002);
        check(INTERNAL_A, 32'h5a5a0003);
        check(INTERNAL_B, 32'h5a5a0004);
        acc(1'b1, 14'h0, 32'hffffffff, 0, 1'b0);
        acc(1'b0, 14'h0, 0, 0, 1'b0);
        acc(1'b1, 14'h3fe0, 32'hffffffff, 0, 1'b0);
        acc(1'b0, 14'h3fe0, 0, 0, 1'b0);
        acc(1'b1, 14'h0018, 32'h1, 0, 1'b1);
        acc(1'b1, 14'h4, 32'h0000046e, 0, 1'b0);
        $display("test control done");
    endtask : t_ctrl

    // Alternating patterns put every field both high and low
    task automatic t_status;
        logic [17:0] pats [3] = '{18'h3ffff, 18'h2aaaa, 18'h15555};
        for (int i = 0; i < 3; i++) begin
            @(negedge CLOCK);
            ANA_IN = pusir_ana_s'(pats[i]);
            repeat (20) @(negedge CLOCK);
            acc(1'b0, 14'h0, 0, exp_st(ANA_IN, 1'b1), 1'b0);
        end
        acc(1'b1, 14'h4, 32'h0000040e, 0, 1'b0);
        @(negedge CLOCK);
        ANA_IN = pusir_ana_s'(18'h3ffff);
        repeat (20) @(negedge CLOCK);
        acc(1'b0, 14'h0, 0, exp_st(ANA_IN, 1'b0), 1'b0);
        acc(1'b1, 14'h4, 32'h0000046e, 0, 1'b0);
        $display("test status done");
    endtask : t_status

    task automatic t_monitor;
        int n;
        @(negedge CLOCK);
        ANA_IN = '0;
        repeat (20) @(negedge CLOCK);
        ANA_IN.bus_supply_first_monitor = 1'b1;
        ANA_IN.contact_supply_monitor = 1'b1;
        n = 0;
        while (BUS_SUPPLY_FIRST_OK !== 1'b1 && n < 100) begin
            @(negedge CLOCK);
            n++;
        end
        check({31'h0, n <= BUS_CYC}, 32'h1);
        repeat (CON_CYC - n) @(negedge CLOCK);
        acc(1'b0, 14'h0, 0, exp_st(ANA_IN, 1'b1), 1'b0);
        $display("test monitor done");
    endtask : t_monitor

    task automatic t_irq;
        acc(1'b1, 14'h3fdc, 32'h00000055, 0, 1'b0);
        acc(1'b0, 14'h3fe4, 0, 32'h55, 1'b0);
        acc(1'b1, 14'h3fd8, 32'h00000011, 0, 1'b0);
        acc(1'b0, 14'h3fe4, 0, 32'h44, 1'b0);
        acc(1'b1, 14'h3fe4, 32'hffffffff, 0, 1'b0);
        acc(1'b0, 14'h3fe4, 0, 32'h7f, 1'b0);
        acc(1'b1, 14'h3fe4, 0, 0, 1'b0);
        @(negedge CLOCK);
        IRQ_EVENT = 7'h08;
        @(negedge CLOCK);
        IRQ_EVENT = 7'h00;
        repeat (4) @(negedge CLOCK);
        acc(1'b0, 14'h3fe0, 0, 32'h08, 1'b0);
        check({31'h0, IRQ}, 0);
        acc(1'b1, 14'h3fdc, 32'h00000008, 0, 1'b0);
        repeat (4) @(negedge CLOCK);
        check({31'h0, IRQ}, 32'h1);
        acc(1'b0, 14'h3fe0, 0, 32'h08, 1'b0);
        acc(1'b1, 14'h3fe8, 32'h00000008, 0, 1'b0);
        acc(1'b0, 14'h3fe0, 0, 0, 1'b0);
        check({31'h0, IRQ}, 0);
        acc(1'b1, 14'h3fec, 32'hffffffff, 0, 1'b0);
        acc(1'b0, 14'h3fe0, 0, 32'h7f, 1'b0);
        acc(1'b1, 14'h3fe8, 32'h0000007f, 0, 1'b0);
        acc(1'b1, 14'h3fec, 32'h00000001, 0, 1'b0);
        acc(1'b1, 14'h3fe8, 32'h00000001, 0, 1'b0);
        acc(1'b0, 14'h3fe0, 0, 0, 1'b0);
        acc(1'b0, 14'h3fec, 0, 0, 1'b0);
        // Event lands on the last cycle the clear strobe is held
        acc(1'b1, 14'h3fe8, 32'h00000020, 0, 1'b0);
        @(negedge CLOCK);
        IRQ_EVENT = 7'h20;
        @(negedge CLOCK);
        IRQ_EVENT = 7'h00;
        acc(1'b0, 14'h3fe0, 0, 32'h20, 1'b0);
        $display("test interrupt done");
    endtask : t_irq

    task automatic finish_test;
        $display("Comparisons %0d, errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (20) @(negedge CLOCK);
        SRST = 1'b0;
        t_reset();
        t_ctrl();
        t_status();
        t_monitor();
        t_irq();
        finish_test();
    end

    // Whole sequence needs well under two thousand cycles
    initial begin
        repeat (20000) @(posedge CLOCK);
        error_cnt++;
        finish_test();
    end
endmodule : pusir_regs_test
